// *** lps_pkg.sv ***
// Purpose: Shared constants for the light and proximity sensor core
// Assumes: 125 MHz system clock
// Notes: Times are kept in their own unit; cycle counts derive from them
package lps_pkg;
    localparam int CLK_MHZ = 125;
    localparam int AMB_CONV_MS = 100;
    localparam int REFL_CONV_US = 540;
    localparam int LED_PULSE_US = 100;
    localparam int SLEEP_MAX_MS = 800;
    localparam int US_DIV = CLK_MHZ;
    localparam int AMB_CONV_US = AMB_CONV_MS * 1000;
    localparam int SLEEP_MAX_US = SLEEP_MAX_MS * 1000;
    localparam int AMB_W = 12;
    localparam int REFL_W = 8;
    localparam int PERS_W = 2;
    localparam int SLEEP_W = 3;
    localparam int UCNT_W = 20;
    localparam logic [PERS_W-1:0] PERS_1 = 2'h0;
    localparam logic [PERS_W-1:0] PERS_4 = 2'h1;
    localparam logic [PERS_W-1:0] PERS_8 = 2'h2;
    localparam logic [PERS_W-1:0] PERS_16 = 2'h3;
    localparam logic [4:0] CNT_1 = 5'h01;
    localparam logic [4:0] CNT_4 = 5'h04;
    localparam logic [4:0] CNT_8 = 5'h08;
    localparam logic [4:0] CNT_16 = 5'h10;
    localparam logic [AMB_W-1:0] AMB_FULL = 12'hfff;
endpackage : lps_pkg

// *** lps_trig_if.sv ***
// Purpose: Carries one channel's trigger event into a persistency filter
// Assumes: Single clock domain
// Notes: done and fire are pulse-style strobes; hit and pers are levels
`timescale 1ns/1ps
`default_nettype none
interface lps_trig_if;
    logic done;
    logic hit;
    logic [lps_pkg::PERS_W-1:0] pers;
    logic fire;
    modport src (output done, output hit, output pers, input fire);
    modport filt (input done, input hit, input pers, output fire);
endinterface : lps_trig_if
`default_nettype wire

// *** lps_persist.sv ***
// Purpose: Counts consecutive triggers and fires at the programmed count
// Assumes: done pulses once per completed conversion
// Notes: A non-triggering result restarts the count
`timescale 1ns/1ps
`default_nettype none
module lps_persist (
    input wire logic i_clk,
    input wire logic i_rstn,
    lps_trig_if.filt trig
);
    typedef struct packed {
        logic [4:0] cnt;
        logic fire;
    } lps_pst_t;
    lps_pst_t st, next_st;
    logic [4:0] need;

    // Required consecutive count and counting
    always_comb begin
        case (trig.pers)
            lps_pkg::PERS_1: need = lps_pkg::CNT_1;
            lps_pkg::PERS_4: need = lps_pkg::CNT_4;
            lps_pkg::PERS_8: need = lps_pkg::CNT_8;
            default: need = lps_pkg::CNT_16;
        endcase
        next_st = st;
        next_st.fire = 1'b0;
        if (trig.done) begin
            if (!trig.hit) begin
                next_st.cnt = 5'h00;
            end else if (st.cnt + 5'h01 >= need) begin
                next_st.cnt = 5'h00;
                next_st.fire = 1'b1;
            end else begin
                next_st.cnt = st.cnt + 5'h01;
            end
        end
    end

    // State register
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign trig.fire = st.fire;
endmodule : lps_persist
`default_nettype wire

// *** lps_core.sv ***
// Purpose: Digital core of an ambient light and reflectance proximity sensor
// Assumes: Converter results arrive as sampled inputs; host bus decoded outside
// Notes: Configuration and status are plain ports; interrupt pin is open drain
//
// Overview of operation
// - Ambient and reflectance channels run independently and concurrently.
// - Each ambient conversion lasts 100 ms; full scale up to 2000 lux.
// - Each reflectance conversion lasts 540 us and yields a result.
// - LED driver turns on during the reflectance conversion.
// - LED pulse is 100 us; sink current selects 110 or 220 mA.
// - Programmable sleep between LED pulses, longest 800 ms.
// - Ambient range select chooses 125 or 2000 lux full scale.
// - Ambient code is proportional to lux within the chosen range.
// - Ambient trigger when result lies outside the low/high window.
// - Reflectance trigger when result exceeds the threshold.
// - Interrupt after 1, 4, 8 or 16 consecutive triggers per channel.
// - Interrupt sets readable flags and drives the interrupt pin.
// - Interrupt pin is open drain: pulls low when active.
// - Ambient result is 12 bits.
// - Reflectance result is 8 bits.
`timescale 1ns/1ps
`default_nettype none
module lps_core #(
    parameter int AMB_CONV_CYC = lps_pkg::AMB_CONV_US * lps_pkg::CLK_MHZ,
    parameter int SLEEP_UNIT_US = lps_pkg::SLEEP_MAX_US / 8
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_ambient_channel_en,
    input wire logic i_refl_en,
    input wire logic i_ambient_range_select,
    input wire logic [lps_pkg::AMB_W-1:0] i_ambient_raw,
    input wire logic [lps_pkg::REFL_W-1:0] i_refl_raw,
    input wire logic [lps_pkg::AMB_W-1:0] i_amb_thr_low,
    input wire logic [lps_pkg::AMB_W-1:0] i_amb_thr_high,
    input wire logic [lps_pkg::REFL_W-1:0] i_refl_thr,
    input wire logic [lps_pkg::PERS_W-1:0] i_amb_pers,
    input wire logic [lps_pkg::PERS_W-1:0] i_refl_pers,
    input wire logic i_led_high_current,
    input wire logic [lps_pkg::SLEEP_W-1:0] i_sleep_sel,
    input wire logic i_amb_flag_clr,
    input wire logic i_refl_flag_clr,
    output logic [lps_pkg::AMB_W-1:0] o_ambient_data,
    output logic [lps_pkg::REFL_W-1:0] o_refl_data,
    output logic o_amb_flag,
    output logic o_refl_flag,
    output logic o_ir_led_sink_on,
    output logic o_ir_led_sink_high,
    output logic o_amb_sample,
    output logic o_refl_sample,
    output logic o_int_n_out,
    output logic o_int_n_oe
);
    localparam int REFL_CYC = lps_pkg::REFL_CONV_US;
    localparam int LED_CYC = lps_pkg::LED_PULSE_US;
    localparam int LED_START = (REFL_CYC - LED_CYC) / 2;
    // Period counter sized from the conversion length; the full period needs more than 20 bits
    localparam int AMB_CNT_W = $clog2(AMB_CONV_CYC + 1);

    typedef enum logic [2:0] {
        RS_IDLE = 3'h1,
        RS_CONV = 3'h2,
        RS_SLEEP = 3'h4
    } lps_rstate_t;

    typedef struct packed {
        logic [6:0] us_div;
        logic us_tick;
        logic [AMB_CNT_W-1:0] amb_cnt;
        logic [lps_pkg::UCNT_W-1:0] refl_cnt;
        lps_rstate_t rst;
        logic [lps_pkg::AMB_W-1:0] amb_data;
        logic [lps_pkg::REFL_W-1:0] refl_data;
        logic amb_done;
        logic amb_hit;
        logic refl_done;
        logic refl_hit;
        logic amb_flag;
        logic refl_flag;
        logic led_on;
        logic led_high;
        logic amb_sample;
        logic refl_sample;
        logic int_oe_n;
    } lps_state_t;

    lps_state_t st, next_st;
    logic [lps_pkg::AMB_W-1:0] amb_code;
    logic [lps_pkg::UCNT_W-1:0] sleep_us;
    logic amb_fire;
    logic refl_fire;

    lps_trig_if amb_if ();
    lps_trig_if refl_if ();

    // Trigger strobes to the persistency filters
    assign amb_if.done = st.amb_done;
    assign amb_if.hit = st.amb_hit;
    assign amb_if.pers = i_amb_pers;
    assign refl_if.done = st.refl_done;
    assign refl_if.hit = st.refl_hit;
    assign refl_if.pers = i_refl_pers;
    assign amb_fire = amb_if.fire;
    assign refl_fire = refl_if.fire;

    // One persistency filter per channel, independent
    lps_persist u_amb_pst (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .trig(amb_if.filt)
    );
    lps_persist u_refl_pst (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .trig(refl_if.filt)
    );

    // Next state of both channels and the interrupt logic
    always_comb begin
        next_st = st;
        next_st.us_tick = 1'b0;
        next_st.amb_done = 1'b0;
        next_st.refl_done = 1'b0;
        next_st.amb_sample = 1'b0;
        next_st.refl_sample = 1'b0;
        // Scale: low range expands 125 lux over the full 12-bit code
        if (i_ambient_range_select) begin
            amb_code = i_ambient_raw;
        end else if (i_ambient_raw[lps_pkg::AMB_W-1:lps_pkg::AMB_W-4] != 4'h0) begin
            amb_code = lps_pkg::AMB_FULL;
        end else begin
            amb_code = {i_ambient_raw[lps_pkg::AMB_W-5:0], 4'h0};
        end
        sleep_us = lps_pkg::UCNT_W'(SLEEP_UNIT_US * (int'(i_sleep_sel) + 1));
        // Microsecond enable from the 125 MHz clock
        if (st.us_div == 7'(lps_pkg::US_DIV - 1)) begin
            next_st.us_div = 7'h00;
            next_st.us_tick = 1'b1;
        end else begin
            next_st.us_div = st.us_div + 7'h01;
        end
        // Ambient channel: free-running conversion period, in clock cycles
        if (!i_ambient_channel_en) begin
            next_st.amb_cnt = '0;
        end else if (st.amb_cnt == AMB_CNT_W'(AMB_CONV_CYC - 1)) begin
            next_st.amb_cnt = '0;
            next_st.amb_data = amb_code;
            next_st.amb_sample = 1'b1;
            next_st.amb_done = 1'b1;
            next_st.amb_hit = (amb_code < i_amb_thr_low) || (amb_code > i_amb_thr_high);
        end else begin
            next_st.amb_cnt = st.amb_cnt + 1'b1;
        end
        // Reflectance channel state machine, in microsecond ticks
        case (st.rst)
            RS_IDLE: begin
                next_st.led_on = 1'b0;
                if (i_refl_en) begin
                    next_st.rst = RS_CONV;
                    next_st.refl_cnt = '0;
                    next_st.led_high = i_led_high_current;
                end
            end
            RS_CONV: begin
                if (st.us_tick) begin
                    next_st.refl_cnt = st.refl_cnt + 1'b1;
                    if (st.refl_cnt == lps_pkg::UCNT_W'(LED_START - 1)) begin
                        next_st.led_on = 1'b1;
                    end
                    if (st.refl_cnt == lps_pkg::UCNT_W'(LED_START + LED_CYC - 1)) begin
                        next_st.led_on = 1'b0;
                        next_st.refl_sample = 1'b1;
                    end
                    if (st.refl_cnt == lps_pkg::UCNT_W'(REFL_CYC - 1)) begin
                        next_st.rst = RS_SLEEP;
                        next_st.refl_cnt = '0;
                        next_st.refl_data = i_refl_raw;
                        next_st.refl_done = 1'b1;
                        next_st.refl_hit = i_refl_raw > i_refl_thr;
                    end
                end
            end
            RS_SLEEP: begin
                next_st.led_on = 1'b0;
                if (!i_refl_en) begin
                    next_st.rst = RS_IDLE;
                end else if (st.us_tick) begin
                    if (st.refl_cnt >= sleep_us - 1'b1) begin
                        next_st.rst = RS_CONV;
                        next_st.refl_cnt = '0;
                        next_st.led_high = i_led_high_current;
                    end else begin
                        next_st.refl_cnt = st.refl_cnt + 1'b1;
                    end
                end
            end
            default: begin
                next_st.rst = RS_IDLE;
                next_st.led_on = 1'b0;
            end
        endcase
        // Sticky flags: the setting event wins over a clear
        if (amb_fire) begin
            next_st.amb_flag = 1'b1;
        end else if (i_amb_flag_clr) begin
            next_st.amb_flag = 1'b0;
        end
        if (refl_fire) begin
            next_st.refl_flag = 1'b1;
        end else if (i_refl_flag_clr) begin
            next_st.refl_flag = 1'b0;
        end
        // Pin drives low while either flag stands
        next_st.int_oe_n = !(next_st.amb_flag || next_st.refl_flag);
    end

    // State register
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st <= '0;
            st.rst <= RS_IDLE;
            st.int_oe_n <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from flip-flops, except the interrupt data output tied low
    assign o_ambient_data = st.amb_data;
    assign o_refl_data = st.refl_data;
    assign o_amb_flag = st.amb_flag;
    assign o_refl_flag = st.refl_flag;
    assign o_ir_led_sink_on = st.led_on;
    assign o_ir_led_sink_high = st.led_high;
    assign o_amb_sample = st.amb_sample;
    assign o_refl_sample = st.refl_sample;
    assign o_int_n_out = 1'b0;
    assign o_int_n_oe = st.int_oe_n;
endmodule : lps_core
`default_nettype wire

// *** lps_core_properties.sv ***
// Purpose: Port-level timing checks for the sensor core
// Assumes: One clock, asynchronous active-low reset
// Notes: Bound into every lps_core instance
`timescale 1ns/1ps
`default_nettype none
module lps_core_properties #(
    parameter int AMB_CONV_CYC = 50
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_ambient_channel_en,
    input wire logic i_amb_flag_clr,
    input wire logic [lps_pkg::AMB_W-1:0] o_ambient_data,
    input wire logic o_amb_flag,
    input wire logic o_refl_flag,
    input wire logic o_ir_led_sink_on,
    input wire logic o_amb_sample,
    input wire logic o_refl_sample,
    input wire logic o_int_n_out,
    input wire logic o_int_n_oe
);
    localparam int LED_CYC = lps_pkg::LED_PULSE_US * lps_pkg::US_DIV;
    logic [15:0] led_cnt;
    int gap;
    logic gap_ok;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    // Count LED on-time and cycles between ambient samples
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            led_cnt <= 16'h0;
            gap <= 0;
            gap_ok <= 1'b0;
        end else begin
            led_cnt <= o_ir_led_sink_on ? led_cnt + 16'h1 : 16'h0;
            gap <= o_amb_sample ? 1 : gap + 1;
            gap_ok <= i_ambient_channel_en && (gap_ok || o_amb_sample);
        end
    end
    a_int_pin_low: assert property (o_int_n_out == 1'b0)
        else $error("interrupt data not low");
    a_int_from_flags: assert property (o_int_n_oe == !(o_amb_flag || o_refl_flag))
        else $error("interrupt pin disagrees with flags");
    a_amb_flag_sticky: assert property (o_amb_flag && !i_amb_flag_clr |=> o_amb_flag)
        else $error("ambient flag dropped without clear");
    a_amb_sample_once: assert property (o_amb_sample |=> !o_amb_sample)
        else $error("ambient sample longer than one cycle");
    a_amb_period: assert property (o_amb_sample && gap_ok |-> gap == AMB_CONV_CYC)
        else $error("ambient period wrong");
    a_amb_data_moves: assert property ($changed(o_ambient_data) |-> o_amb_sample)
        else $error("ambient data changed without sample");
    a_led_pulse_width: assert property ($fell(o_ir_led_sink_on) |-> led_cnt == LED_CYC)
        else $error("LED pulse width wrong");
    a_led_then_sample: assert property ($fell(o_ir_led_sink_on) |-> ##[0:1] o_refl_sample)
        else $error("no reflectance sample at LED off");
endmodule : lps_core_properties
bind lps_core lps_core_properties #(.AMB_CONV_CYC(AMB_CONV_CYC)) u_props (.i_clk(i_clk), .i_rstn(i_rstn),
    .i_ambient_channel_en(i_ambient_channel_en), .i_amb_flag_clr(i_amb_flag_clr), .o_ambient_data(o_ambient_data),
    .o_amb_flag(o_amb_flag), .o_refl_flag(o_refl_flag), .o_ir_led_sink_on(o_ir_led_sink_on),
    .o_amb_sample(o_amb_sample), .o_refl_sample(o_refl_sample), .o_int_n_out(o_int_n_out), .o_int_n_oe(o_int_n_oe));
`default_nettype wire

// *** lps_host_model.sv ***
// Purpose: Host side: pulled-up interrupt line and flag servicing
// Assumes: Bench holds the service request until the line releases
// Notes: Clears only flags that are seen set
`timescale 1ns/1ps
`default_nettype none
module lps_host_model (
    input wire logic i_svc,
    input wire logic i_int_n_out,
    input wire logic i_int_n_oe,
    input wire logic i_amb_flag,
    input wire logic i_refl_flag,
    output logic o_int_line,
    output logic o_amb_clr,
    output logic o_refl_clr
);
    // Released pin floats high through the pull-up
    assign o_int_line = i_int_n_oe ? 1'b1 : i_int_n_out;
    // Read the flags after an interrupt and clear those set
    assign o_amb_clr = i_svc && !o_int_line && i_amb_flag;
    assign o_refl_clr = i_svc && !o_int_line && i_refl_flag;
endmodule : lps_host_model
`default_nettype wire

// *** light_proximity_sensor_core_test.sv ***
// Purpose: Self-checking bench for the sensor core
// Assumes: Short ambient period and sleep unit via parameters
// Notes: Inputs change at the falling edge
`timescale 1ns/1ps
`default_nettype none
module light_proximity_sensor_core_test;
    localparam int P = 50;
    logic i_clk = 1'b0, i_rstn = 1'b0, amb_en = 1'b0, refl_en = 1'b0, rng = 1'b1, led_hc = 1'b0, svc = 1'b0;
    logic [11:0] amb_raw = 12'h0, thr_lo = 12'h0, thr_hi = 12'hfff, amb_data;
    logic [7:0] refl_raw = 8'h0, refl_thr = 8'hff, refl_data;
    logic [1:0] amb_pers = 2'h0, refl_pers = 2'h0;
    logic [2:0] sleep_sel = 3'h0;
    logic amb_clr, refl_clr, amb_flag, refl_flag, led_on, led_high, amb_smp, refl_smp, int_out, int_oe, int_line;
    int mismatches = 0, n_compared = 0, cycles = 0;
    // Clock and timeout
    always #4 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 95000) begin
            mismatches++;
            close_out();
        end
    end
    lps_core #(.AMB_CONV_CYC(P), .SLEEP_UNIT_US(2)) dut (.i_clk(i_clk), .i_rstn(i_rstn),
        .i_ambient_channel_en(amb_en), .i_refl_en(refl_en), .i_ambient_range_select(rng), .i_ambient_raw(amb_raw),
        .i_refl_raw(refl_raw), .i_amb_thr_low(thr_lo), .i_amb_thr_high(thr_hi), .i_refl_thr(refl_thr),
        .i_amb_pers(amb_pers), .i_refl_pers(refl_pers), .i_led_high_current(led_hc), .i_sleep_sel(sleep_sel),
        .i_amb_flag_clr(amb_clr), .i_refl_flag_clr(refl_clr), .o_ambient_data(amb_data), .o_refl_data(refl_data),
        .o_amb_flag(amb_flag), .o_refl_flag(refl_flag), .o_ir_led_sink_on(led_on), .o_ir_led_sink_high(led_high),
        .o_amb_sample(amb_smp), .o_refl_sample(refl_smp), .o_int_n_out(int_out), .o_int_n_oe(int_oe));
    lps_host_model host (.i_svc(svc), .i_int_n_out(int_out), .i_int_n_oe(int_oe), .i_amb_flag(amb_flag),
        .i_refl_flag(refl_flag), .o_int_line(int_line), .o_amb_clr(amb_clr), .o_refl_clr(refl_clr));
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
            mismatches++;
        end
    endtask : check
    task automatic wait_amb();
        int k;
        k = 0;
        do begin
            @(negedge i_clk);
            k++;
        end while (amb_smp !== 1'b1 && k < 2 * P);
        check("ambient sample", 1, amb_smp);
    endtask : wait_amb
    task automatic amb_case(input logic r, input logic [11:0] raw, input logic [11:0] exp);
        rng = r;
        amb_raw = raw;
        wait_amb();
        check("ambient data", exp, amb_data);
    endtask : amb_case
    task automatic clear();
        int k;
        svc = 1'b1;
        k = 0;
        do begin
            @(negedge i_clk);
            k++;
        end while (k < 8 && int_line !== 1'b1);
        svc = 1'b0;
        check("line released", 1, int_line);
    endtask : clear
    task automatic t_range();
        wait_amb();
        amb_case(1'b1, 12'h123, 12'h123);
        amb_case(1'b0, 12'h0ab, 12'hab0);
        amb_case(1'b0, 12'h100, 12'hfff);
        $display("range test done");
    endtask : t_range
    task automatic t_pers();
        int n;
        rng = 1'b1;
        thr_lo = 12'h010;
        thr_hi = 12'h800;
        for (int p = 0; p < 4; p++) begin
            n = (p == 0) ? 1 : 2 << p;
            amb_pers = p[1:0];
            amb_raw = 12'h800;
            wait_amb();
            wait_amb();
            clear();
            check("flag at edge", 0, amb_flag);
            amb_raw = 12'h801;
            for (int k = 1; k <= n; k++) begin
                wait_amb();
                repeat (3) @(negedge i_clk);
                check("ambient flag", k == n, amb_flag);
            end
            check("line", 0, int_line);
        end
        clear();
        amb_pers = 2'h0;
        amb_raw = 12'h00f;
        wait_amb();
        repeat (3) @(negedge i_clk);
        check("low flag", 1, amb_flag);
        clear();
        $display("persistency test done");
    endtask : t_pers
    task automatic t_refl();
        int k, w, seen;
        thr_lo = 12'h000;
        thr_hi = 12'hfff;
        refl_thr = 8'h40;
        refl_raw = 8'h41;
        led_hc = 1'b1;
        refl_en = 1'b1;
        seen = 0;
        for (k = 0; k < 30000 && led_on !== 1'b1; k++) @(negedge i_clk);
        check("led current", 1, led_high);
        for (w = 0; w < 20000 && led_on === 1'b1; w++) begin
            seen = seen + (amb_smp === 1'b1);
            @(negedge i_clk);
        end
        check("led width", 16'(lps_pkg::LED_PULSE_US * lps_pkg::US_DIV), w[15:0]);
        check("both channels", 1, seen != 0);
        refl_en = 1'b0;
        for (k = 0; k < 30000 && refl_flag !== 1'b1; k++) @(negedge i_clk);
        check("refl flag", 1, refl_flag);
        check("refl data", 16'h41, {8'h0, refl_data});
        check("line", 0, int_line);
        clear();
        check("refl cleared", 0, refl_flag);
        $display("reflectance test done");
    endtask : t_refl
    task automatic close_out();
        $display("compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : close_out
    // Main sequence
    initial begin
        repeat (4) @(negedge i_clk);
        i_rstn = 1'b1;
        amb_en = 1'b1;
        t_range();
        t_pers();
        t_refl();
        close_out();
    end
endmodule : light_proximity_sensor_core_test
`default_nettype wire
